// file: rtl/pcu_device.sv
// Card unit control: cycle sequencer, selection latch and row exchange
// What this block does
// - Field III transfer optional when switch out
// - Start bit required; runs one machine cycle
// - Cycle is 500 ms of 18 points
// - Points run 14..18, 9..1, 0, 11..13
// - By-command interrupt at row point starts
// - Locked-in switch interrupts without command bit
// - Host reads first row within 10 ms
// - Host writes first row within 1.5 ms
// - Run free repeats cycles until stop
// - Stop after point zero, one more cycle
// - Pick bit feeds station 1, advances 1->2
// - Punch bit accepts row data for punching
// - Read bit senses each passing row on a row interrupt
// - Selections latched for cycle or run
// - Cards at station 2+ advance each cycle
// - Punch rows received during 2->3 cycle
// - Card punched at next cycle start
// - Read rows presented during station 2 cycle
// - Row is field III, I, II transfers
`timescale 1ns/1ns
`default_nettype none
module pcu_device #(
    parameter longint POINT_CYCLES = pcu_pkg::POINT_CLKS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic clkEn,
    // Link to host
    pcu_link_if.device link,
    // Cabinet switches
    input wire logic field3Enable,
    input wire logic intrLockedIn,
    // Card sensing and mechanism
    input wire logic [pcu_pkg::CMD_W-1:0] brushRow,
    output logic [pcu_pkg::CMD_W-1:0] punchRow,
    output logic punchRowValid,
    output logic punchFire,
    output logic [pcu_pkg::STATIONS-1:0] readStations,
    output logic [pcu_pkg::STATIONS-1:0] punchStations,
    output logic [4:0] cyclePoint,
    output logic running
);
    import pcu_pkg::*;

    // ----------------------------------------
    // Point timer and sequencer
    // ----------------------------------------
    logic [31:0] tick_ff;
    logic [4:0] point_ff;
    pcu_state_t state_ff;
    logic pointEnd;
    logic cycleEnd;
    logic [CMD_W-1:0] sel_ff;
    logic stopPend_ff;
    logic punchDue_ff;
    logic [CMD_W-1:0] prim_ff;
    logic [CMD_W-1:0] sec_ff;
    logic [1:0] xcnt_ff;
    logic intr_ff;
    logic [STATIONS-1:0] rd_ff;
    logic [STATIONS-1:0] pn_ff;
    logic startCmd;

    assign pointEnd = state_ff != PCU_IDLE && tick_ff == 32'(POINT_CYCLES - 1);
    assign cycleEnd = pointEnd && point_ff == PT_LAST;
    assign startCmd = link.funcValid && link.funcCmd[BIT_START];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick_ff <= 32'h0000_0000;
        end else if (clkEn) begin
            if (state_ff == PCU_IDLE || pointEnd) tick_ff <= 32'h0000_0000;
            else tick_ff <= tick_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            point_ff <= PT_FIRST;
        end else if (clkEn) begin
            if (state_ff == PCU_IDLE) point_ff <= PT_FIRST;
            else if (pointEnd) point_ff <= pcu_next_point(point_ff);
        end
    end

    // 18 points make one cycle; run free repeats; stop takes one more
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= PCU_IDLE;
        end else if (clkEn) begin
            unique case (state_ff)
                PCU_IDLE: begin
                    if (startCmd) state_ff <= PCU_RUN;
                end
                PCU_RUN: begin
                    if (cycleEnd) begin
                        if (stopPend_ff) state_ff <= PCU_LAST;
                        else if (sel_ff[BIT_RUN_FREE]) state_ff <= PCU_RUN;
                        else if (startCmd) state_ff <= PCU_RUN;
                        else state_ff <= PCU_IDLE;
                    end
                end
                PCU_LAST: begin
                    if (cycleEnd) state_ff <= PCU_IDLE;
                end
                default: state_ff <= PCU_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Selection latch
    // ----------------------------------------
    // hold selections so the buffer can be reused
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_ff <= '0;
        end else if (clkEn) begin
            if (startCmd && (state_ff == PCU_IDLE || cycleEnd && !sel_ff[BIT_RUN_FREE]))
                sel_ff <= link.funcCmd;
            else if (state_ff == PCU_LAST && cycleEnd)
                sel_ff <= '0;
            else if (state_ff == PCU_RUN && cycleEnd && !sel_ff[BIT_RUN_FREE] && !startCmd)
                sel_ff <= '0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stopPend_ff <= 1'b0;
        end else if (clkEn) begin
            if (state_ff == PCU_IDLE) stopPend_ff <= 1'b0;
            else if (startCmd && link.funcCmd[BIT_STOP] && sel_ff[BIT_RUN_FREE])
                stopPend_ff <= 1'b1;
            else if (cycleEnd && state_ff == PCU_LAST) stopPend_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Card stations
    // ----------------------------------------
    // pick loads station 1 and moves 1->2; 2+ always advance
    function automatic logic [STATIONS-1:0] advance(
        input logic [STATIONS-1:0] s, input logic pick);
        logic [STATIONS-1:0] n;
        n = {s[STATIONS-2:1], 2'b00};
        n[1] = pick & s[0];
        n[0] = pick ? 1'b1 : s[0];
        return n;
    endfunction

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_ff <= '0;
            pn_ff <= '0;
        end else if (clkEn && cycleEnd) begin
            rd_ff <= advance(rd_ff, sel_ff[BIT_PICK_RD]);
            pn_ff <= advance(pn_ff, sel_ff[BIT_PICK_PN]);
        end
    end

    // punch whole card at start of next cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            punchDue_ff <= 1'b0;
            punchFire <= 1'b0;
        end else if (clkEn) begin
            punchFire <= 1'b0;
            if (cycleEnd) begin
                punchDue_ff <= sel_ff[BIT_PUNCH] && pn_ff[1];
            end else if (punchDue_ff && state_ff != PCU_IDLE && point_ff == PT_FIRST
                && tick_ff == 32'h0000_0000) begin
                // First clock of the next cycle, before the card moves on
                punchFire <= 1'b1;
                punchDue_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Row interrupt and data exchange
    // ----------------------------------------
    logic rowActive;
    logic nextRow;
    assign rowActive = sel_ff[BIT_READ] || sel_ff[BIT_PUNCH];
    assign nextRow = pcu_is_row(pcu_next_point(point_ff));

    // by-command interrupt; locked-in switch forces it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            intr_ff <= 1'b0;
        end else if (clkEn) begin
            intr_ff <= pointEnd && nextRow && rowActive
                && (sel_ff[BIT_INTR] || intrLockedIn);
        end
    end

    // field III first (if enabled), then fields I and II
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            xcnt_ff <= 2'b00;
        end else if (clkEn) begin
            if (pointEnd) xcnt_ff <= 2'b00;
            else if (link.xferValid && link.xferSel == SEL_FIELD12 && xcnt_ff != 2'b10)
                xcnt_ff <= xcnt_ff + 2'b01;
        end
    end

    // brushes present row in both buffers; secondary cleared when field III is out
    // punch accepts rows from fields I and II only; field III writes go to the secondary buffer only when field3Enable is set
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prim_ff <= '0;
            sec_ff <= '0;
            punchRow <= '0;
            punchRowValid <= 1'b0;
        end else if (clkEn) begin
            punchRowValid <= 1'b0;
            if (intr_ff && sel_ff[BIT_READ] && rd_ff[1]) begin
                prim_ff <= brushRow;
                sec_ff <= field3Enable ? brushRow : '0;
            end
            if (link.xferValid && link.xferWrite && sel_ff[BIT_PUNCH] && pn_ff[1]) begin
                if (link.xferSel == SEL_FIELD3) begin
                    if (field3Enable) sec_ff <= link.hostData;
                end else if (xcnt_ff != 2'b10) begin
                    // Only fields I and II per row; extra transfers are dropped
                    punchRow <= link.hostData;
                    punchRowValid <= 1'b1;
                end
            end
        end
    end

    assign link.xferAck = link.xferValid && clkEn;
    assign link.rowIntr = intr_ff;
    assign link.primaryData = prim_ff;
    assign link.secondaryData = sec_ff;
    assign readStations = rd_ff;
    assign punchStations = pn_ff;
    assign cyclePoint = point_ff;
    assign running = state_ff != PCU_IDLE;
endmodule
`default_nettype wire

// file: rtl/pcu_host.sv
// Host side: issues function commands and row transfers on interrupt
`timescale 1ns/1ns
`default_nettype none
module pcu_host (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic clkEn,
    // User requests
    input wire logic cmdReq,
    input wire logic [pcu_pkg::CMD_W-1:0] cmdWord,
    input wire logic doWrite,
    input wire logic useField3,
    input wire logic [pcu_pkg::CMD_W-1:0] wrField3,
    input wire logic [pcu_pkg::CMD_W-1:0] wrField1,
    input wire logic [pcu_pkg::CMD_W-1:0] wrField2,
    output logic [pcu_pkg::CMD_W-1:0] rdData,
    output logic [1:0] rdField,
    output logic rdValid,
    output logic lateFlag,
    // Link to device
    pcu_link_if.host link
);
    import pcu_pkg::*;

    logic [1:0] step_ff;
    logic busy_ff;
    logic [31:0] wait_ff;

    // ----------------------------------------
    // Row exchange sequencer
    // ----------------------------------------
    // three transfers per row; two without useField3, which omits selector zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_ff <= 1'b0;
            step_ff <= 2'b00;
        end else if (clkEn) begin
            if (link.rowIntr) begin
                busy_ff <= 1'b1;
                step_ff <= useField3 ? 2'b00 : 2'b01;
            end else if (busy_ff && link.xferAck) begin
                if (step_ff == 2'b10) busy_ff <= 1'b0;
                step_ff <= step_ff + 2'b01;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_ff <= 32'h0000_0000;
            lateFlag <= 1'b0;
        end else if (clkEn) begin
            if (link.rowIntr) wait_ff <= 32'h0000_0000;
            else if (busy_ff) wait_ff <= wait_ff + 32'h0000_0001;
            if (busy_ff && wait_ff >= 32'(doWrite ? WRITE_DL_CLKS : READ_DL_CLKS))
                lateFlag <= 1'b1;
        end
    end

    assign link.xferValid = busy_ff;
    assign link.xferWrite = doWrite;
    assign link.xferSel = (step_ff == 2'b00) ? SEL_FIELD3 : SEL_FIELD12;
    assign link.hostData = (step_ff == 2'b00) ? wrField3 :
        (step_ff == 2'b01) ? wrField1 : wrField2;
    // start bit always added to commands
    assign link.funcValid = cmdReq;
    assign link.funcCmd = cmdWord | (CMD_W'(1) << BIT_START);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdData <= '0;
            rdField <= 2'b00;
            rdValid <= 1'b0;
        end else if (clkEn) begin
            rdValid <= busy_ff && link.xferAck && !doWrite;
            if (busy_ff && link.xferAck && !doWrite) begin
                rdField <= step_ff;
                rdData <= (step_ff == 2'b00) ? link.secondaryData : link.primaryData;
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/pcu_link_if.sv
// Link between the host computer and the card unit control
`timescale 1ns/1ns
`default_nettype none
interface pcu_link_if;
    import pcu_pkg::*;
    logic funcValid;
    logic [CMD_W-1:0] funcCmd;
    logic rowIntr;
    logic xferValid;
    logic xferWrite;
    logic xferSel;
    logic [CMD_W-1:0] hostData;
    logic [CMD_W-1:0] primaryData;
    logic [CMD_W-1:0] secondaryData;
    logic xferAck;

    modport device (
        input funcValid, funcCmd, xferValid, xferWrite, xferSel, hostData,
        output rowIntr, primaryData, secondaryData, xferAck
    );
    modport host (
        output funcValid, funcCmd, xferValid, xferWrite, xferSel, hostData,
        input rowIntr, primaryData, secondaryData, xferAck
    );
endinterface
`default_nettype wire

// file: rtl/pcu_pkg.sv
// Shared constants and types for the punched card unit control link
package pcu_pkg;
    // ----------------------------------------
    // Command buffer field positions
    // ----------------------------------------
    localparam int CMD_W = 36;
    localparam int BIT_READ = 0;
    localparam int BIT_PUNCH = 1;
    localparam int BIT_PICK_RD = 2;
    localparam int BIT_PICK_PN = 3;
    localparam int BIT_STOP = 4;
    localparam int BIT_RUN_FREE = 5;
    localparam int BIT_INTR = 7;
    localparam int BIT_START = 35;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam longint CYCLE_MS = 500;
    localparam int POINTS = 18;
    localparam longint POINT_NS = CYCLE_MS * 1000000 / POINTS;
    localparam longint POINT_CLKS = POINT_NS / CLK_PERIOD_NS;
    localparam longint READ_DL_US = 10000;
    localparam longint WRITE_DL_US = 1500;
    localparam longint READ_DL_CLKS = READ_DL_US * 1000 / CLK_PERIOD_NS;
    localparam longint WRITE_DL_CLKS = WRITE_DL_US * 1000 / CLK_PERIOD_NS;
    // ----------------------------------------
    // Cycle point sequence and stations
    // ----------------------------------------
    localparam logic [4:0] PT_FIRST = 5'h0_00E;
    localparam logic [4:0] PT_LAST = 5'h0_00D;
    localparam int STATIONS = 5;
    // Transfer selector values
    localparam logic SEL_FIELD3 = 1'b0;
    localparam logic SEL_FIELD12 = 1'b1;

    typedef enum logic [2:0] {
        PCU_IDLE = 3'b001,
        PCU_RUN = 3'b010,
        PCU_LAST = 3'b100
    } pcu_state_t;

    // Next cycle point in 14..18, 9..1, 0, 11, 12, 13 order
    function automatic logic [4:0] pcu_next_point(input logic [4:0] p);
        logic [4:0] n;
        n = p;
        if (p >= 5'h0_00E && p < 5'h0_012) n = p + 5'h0_001;
        else if (p == 5'h0_012) n = 5'h0_009;
        else if (p >= 5'h0_001 && p <= 5'h0_009) n = p - 5'h0_001;
        else if (p == 5'h0_000) n = 5'h0_00B;
        else if (p == 5'h0_00B || p == 5'h0_00C) n = p + 5'h0_001;
        else n = 5'h0_00E;
        return n;
    endfunction

    // Row points are 9..0, 11 and 12
    function automatic logic pcu_is_row(input logic [4:0] p);
        return (p <= 5'h0_009) || p == 5'h0_00B || p == 5'h0_00C;
    endfunction
endpackage

// file: test/pcu_link_assertions.sv
// Concurrent checks on the host to card unit link
`timescale 1ns/1ns
`default_nettype none
module pcu_link_assertions #(
    parameter int PT_CLKS = 50
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic clkEn,
    // Link signals
    input wire logic funcValid,
    input wire logic [pcu_pkg::CMD_W-1:0] funcCmd,
    input wire logic rowIntr,
    input wire logic xferValid,
    input wire logic xferAck,
    // Device progress
    input wire logic [4:0] cyclePoint,
    input wire logic running
);
    import pcu_pkg::*;
    int ptAge_ff;
    int runLen_ff;
    logic [4:0] lastPt_ff;

    function automatic logic [4:0] pointAfter(input logic [4:0] p);
        if (p == 5'h12) return 5'h09;
        if (p == 5'h00) return 5'h0B;
        if (p == 5'h0D) return 5'h0E;
        if (p >= 5'h01 && p <= 5'h09) return p - 5'h01;
        return p + 5'h01;
    endfunction

    function automatic logic isRow(input logic [4:0] p);
        return p <= 5'h09 || p == 5'h0B || p == 5'h0C;
    endfunction

    // Age of the current point and of the running state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ptAge_ff <= 0;
            lastPt_ff <= 5'h0E;
        end else begin
            ptAge_ff <= (cyclePoint != lastPt_ff) ? 1 : ptAge_ff + 1;
            lastPt_ff <= cyclePoint;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            runLen_ff <= 0;
        end else begin
            runLen_ff <= running ? runLen_ff + 1 : 0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    xfer_ack_follows_a: assert property (
        xferAck == (xferValid && clkEn)) else $error("transfer ack mismatch");
    point_order_a: assert property (
        $changed(cyclePoint) |-> cyclePoint == pointAfter($past(cyclePoint)))
        else $error("cycle point out of order");
    point_legal_a: assert property (
        cyclePoint <= 5'h12 && cyclePoint != 5'h0A) else $error("cycle point illegal");
    point_length_a: assert property (
        $changed(cyclePoint) && $past(cyclePoint) != 5'h0E |-> ptAge_ff == PT_CLKS)
        else $error("cycle point length wrong");
    cycle_length_a: assert property (
        $fell(running) |-> runLen_ff % (POINTS * PT_CLKS) == 0)
        else $error("machine cycle length wrong");
    intr_row_only_a: assert property (
        rowIntr |-> running && isRow(cyclePoint)) else $error("interrupt off a row point");
    intr_single_pulse_a: assert property (
        rowIntr |=> !rowIntr) else $error("interrupt longer than one clock");
    intr_point_start_a: assert property (
        $rose(rowIntr) |-> $past(cyclePoint, 2) != cyclePoint)
        else $error("interrupt not at point start");
    start_taken_a: assert property (
        funcValid && funcCmd[BIT_START] && clkEn && !running |=> running)
        else $error("start command not taken");
    idle_holds_a: assert property (
        !running && !(funcValid && funcCmd[BIT_START]) |=> !running)
        else $error("cycle began without start");

    cover property (rowIntr);
    cover property (xferValid && xferAck);
    cover property ($fell(running));
    cover property (running && runLen_ff == 2 * POINTS * PT_CLKS);
endmodule
`default_nettype wire

// file: test/punched_card_unit_control_test.sv
// Self-checking bench joining the host and card unit control ends
`timescale 1ns/1ns
`default_nettype none
module punched_card_unit_control_test;
    import pcu_pkg::*;
    localparam int PT_CLKS = 50;
    localparam int CYC = POINTS * PT_CLKS;
    localparam logic [CMD_W-1:0] START = 36'h8_0000_0000;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic clkEn = 1'b1;
    logic field3Enable = 1'b1;
    logic intrLockedIn = 1'b0;
    logic [CMD_W-1:0] brushRow = 36'h0_0000_0000;
    logic cmdReq = 1'b0;
    logic [CMD_W-1:0] cmdWord = 36'h0_0000_0000;
    logic doWrite = 1'b1;
    logic useField3 = 1'b1;
    logic [CMD_W-1:0] wrField3 = 36'h0_0000_0A5A;
    logic [CMD_W-1:0] wrField1 = 36'h1_2345_6789;
    logic [CMD_W-1:0] wrField2 = 36'hF_EDCB_A987;
    logic [CMD_W-1:0] punchRow, rdData;
    logic [STATIONS-1:0] readStations, punchStations;
    logic [4:0] cyclePoint;
    logic [1:0] rdField;
    logic punchRowValid, punchFire, running, rdValid, lateFlag;
    int num_errors = 0;
    int num_checks = 0;
    int nIntr, nSel0, nSel1, nRd, nFire, nRow;
    logic [4:0] pnExp [3] = '{5'h09, 5'h11, 5'h01};

    pcu_link_if link();
    pcu_device #(.POINT_CYCLES(PT_CLKS)) u_pcu_device (.clk(clk), .nrst(nrst),
        .clkEn(clkEn), .link(link), .field3Enable(field3Enable),
        .intrLockedIn(intrLockedIn), .brushRow(brushRow), .punchRow(punchRow),
        .punchRowValid(punchRowValid), .punchFire(punchFire), .readStations(readStations),
        .punchStations(punchStations), .cyclePoint(cyclePoint), .running(running));
    pcu_host u_pcu_host (.clk(clk), .nrst(nrst), .clkEn(clkEn), .cmdReq(cmdReq),
        .cmdWord(cmdWord), .doWrite(doWrite), .useField3(useField3), .wrField3(wrField3),
        .wrField1(wrField1), .wrField2(wrField2), .rdData(rdData), .rdField(rdField),
        .rdValid(rdValid), .lateFlag(lateFlag), .link(link));
    pcu_link_assertions #(.PT_CLKS(PT_CLKS)) u_pcu_link_assertions (.clk(clk),
        .nrst(nrst), .clkEn(clkEn), .funcValid(link.funcValid), .funcCmd(link.funcCmd),
        .rowIntr(link.rowIntr), .xferValid(link.xferValid), .xferAck(link.xferAck),
        .cyclePoint(cyclePoint), .running(running));

    always #2 clk = ~clk;
    // Sensed row pattern follows the point
    always @(negedge clk) brushRow <= {31'h0000_0000, cyclePoint};
    always @(posedge clk) begin
        if (link.rowIntr === 1'b1) nIntr += 1;
        if ((link.xferValid && link.xferAck && !link.xferSel) === 1'b1) nSel0 += 1;
        if ((link.xferValid && link.xferAck && link.xferSel) === 1'b1) nSel1 += 1;
        if (rdValid === 1'b1) nRd += 1;
        if (punchFire === 1'b1) nFire += 1;
        if (punchRowValid === 1'b1) nRow += 1;
    end

    function automatic logic [CMD_W-1:0] sel(input int b);
        return 36'h0_0000_0001 << b;
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check_bits(input logic [CMD_W-1:0] got, input logic [CMD_W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_count(input logic [CMD_W-1:0] got, input int exp);
        check_bits(got, 36'(exp));
    endtask
    // Bounded wait for the running level
    task automatic wait_running(input logic lvl, input int limit);
        int n;
        n = 0;
        while (running !== lvl && n < limit) begin
            @(negedge clk);
            n++;
        end
        if (running !== lvl) begin
            check_bits(36'(running), 36'(lvl));
            end_sim();
        end
    endtask
    task automatic send_cmd(input logic [CMD_W-1:0] cmd);
        @(negedge clk);
        cmdWord = cmd;
        cmdReq = 1'b1;
        @(negedge clk);
        cmdReq = 1'b0;
    endtask
    task automatic run_cycle(input logic [CMD_W-1:0] cmd);
        wait_running(1'b0, 4 * CYC);
        send_cmd(cmd);
        wait_running(1'b1, 8);
        wait_running(1'b0, 2 * CYC);
    endtask
    task automatic clear_counts();
        {nIntr, nSel0, nSel1, nRd, nFire, nRow} = '0;
    endtask

    initial begin
        clear_counts();
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        check_count(cyclePoint, 14);
        // ------------------------------------------------------------
        // Punch channel: pick, receive rows, punch, clear
        // ------------------------------------------------------------
        run_cycle(START | sel(BIT_PICK_PN));
        check_count(punchStations, 1);
        run_cycle(START | sel(BIT_PICK_PN));
        check_count(punchStations, 3);
        clear_counts();
        run_cycle(START | sel(BIT_PUNCH) | sel(BIT_INTR));
        check_count(nIntr, 12);
        check_count(nSel0, 12);
        check_count(nSel1, 24);
        check_count(nRow, 24);
        check_bits(punchRow, wrField2);
        check_bits(link.secondaryData, wrField3);
        check_count(punchStations, 5);
        check_bits(36'(lateFlag), 36'h0_0000_0000);
        for (int i = 0; i < 3; i++) begin
            run_cycle(START);
            check_count(punchStations, pnExp[i]);
        end
        check_count(nFire, 1);
        check_count(readStations, 0);
        $display("test punch done");
        // ------------------------------------------------------------
        // Read channel without field three, locked-in interrupt
        // ------------------------------------------------------------
        doWrite = 1'b0;
        useField3 = 1'b0;
        field3Enable = 1'b0;
        intrLockedIn = 1'b1;
        run_cycle(START | sel(BIT_PICK_RD));
        run_cycle(START | sel(BIT_PICK_RD));
        check_count(readStations, 3);
        clear_counts();
        run_cycle(START | sel(BIT_READ));
        check_count(nIntr, 12);
        check_count(nSel0, 0);
        check_count(nRd, 24);
        check_bits(rdData, 36'h0_0000_000C);
        check_count(rdField, 2);
        check_bits(36'(lateFlag), 36'h0_0000_0000);
        check_count(readStations, 5);
        intrLockedIn = 1'b0;
        clear_counts();
        run_cycle(START | sel(BIT_READ));
        check_count(nIntr, 0);
        check_count(readStations, 9);
        $display("test read done");
        // ------------------------------------------------------------
        // Run free, then stop with one further cycle
        // ------------------------------------------------------------
        clear_counts();
        send_cmd(START | sel(BIT_RUN_FREE) | sel(BIT_READ) | sel(BIT_INTR));
        wait_running(1'b1, 8);
        repeat (2 * CYC + 6 * PT_CLKS + PT_CLKS / 2) @(negedge clk);
        check_bits(36'(running), 36'h0_0000_0001);
        check_count(nIntr, 26);
        send_cmd(START | sel(BIT_STOP));
        repeat (CYC) @(negedge clk);
        check_bits(36'(running), 36'h0_0000_0001);
        wait_running(1'b0, CYC);
        check_count(nIntr, 48);
        $display("test run free done");
        end_sim();
    end
endmodule
`default_nettype wire
